/* File: logic/ddrb_ctl_end.sv */
// controller end: makes the clock pair and issues queued bursts
`timescale 1ns/1ps
module ddrb_ctl_end
   import ddrb_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   ddrb_link_if.ctl lk,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic cmd_write_i,
   input wire logic [ADDR_W-1:0] cmd_addr_i,
   input wire logic [DATA_W-1:0] cmd_wdata0_i,
   input wire logic [DATA_W-1:0] cmd_wdata1_i,
   input wire logic dll_bypass_req_i,
   output logic rd_valid_o,
   output logic [DATA_W-1:0] rd_data0_o,
   output logic [DATA_W-1:0] rd_data1_o
);
   logic [3:0] div_r;
   logic k_r;
   logic kn_r;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic ready_r;
   logic e_w [2];
   logic [ADDR_W-1:0] e_a [2];
   logic [DATA_W-1:0] e_d0 [2];
   logic [DATA_W-1:0] e_d1 [2];
   logic [1:0] pop;
   logic push;
   logic slot;
   logic issue_r;
   logic issue_w;
   logic ri;
   logic wi;
   logic rd_last_r;
   logic rd_n_r;
   logic wr_n_r;
   logic byp_n_r;
   logic [ADDR_W-1:0] addr_r;
   logic [DATA_W-1:0] wd_r;
   logic pw_act_r;
   logic [ADDR_W-1:0] pw_addr_r;
   logic [DATA_W-1:0] pw_d1_r;
   logic ep_r;
   logic rv_r;
   logic [DATA_W-1:0] rd0_r;
   logic [DATA_W-1:0] rd1_r;

   // clock pair from a divider; K_FREQ_KHZ stays far below BYPASS_FMAX_MHZ
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         div_r <= '0;
         k_r <= 1'b1;
         kn_r <= 1'b0;
      end else begin
         div_r <= (div_r == DIV_LAST) ? 4'h0 : div_r + 4'h1;
         if (div_r == DIV_LAST) begin
            k_r <= 1'b1;
            kn_r <= 1'b0;
         end else if (div_r == DIV_FALL) begin
            k_r <= 1'b0;
            kn_r <= 1'b1;
         end
      end
   end

   assign slot = (div_r == SLOT_RISE_PREP);
   assign push = cmd_valid_i & ready_r;

   // issue in order; a read may pair with a write on one edge
   always_comb begin
      issue_r = 1'b0;
      issue_w = 1'b0;
      ri = 1'b0;
      wi = 1'b0;
      pop = 2'h0;
      if (slot && cnt_r != 2'h0) begin
         if (e_w[0]) begin
            issue_w = 1'b1;
            pop = 2'h1;
            if (cnt_r == 2'h2 && !e_w[1] && !rd_last_r) begin
               issue_r = 1'b1;
               ri = 1'b1;
               pop = 2'h2;
            end
         end else if (!rd_last_r) begin
            issue_r = 1'b1;
            pop = 2'h1;
            if (cnt_r == 2'h2 && e_w[1]) begin
               issue_w = 1'b1;
               wi = 1'b1;
               pop = 2'h2;
            end
         end
      end
      cnt_nxt = cnt_r - pop + {1'b0, push};
   end

   // two-entry queue; ready falls when both entries are taken
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cnt_r <= '0;
         ready_r <= 1'b0;
         for (int i = 0; i < 2; i++) begin
            e_w[i] <= 1'b0;
            e_a[i] <= '0;
            e_d0[i] <= '0;
            e_d1[i] <= '0;
         end
      end else begin
         cnt_r <= cnt_nxt;
         ready_r <= (cnt_nxt != 2'h2);
         if (pop == 2'h1) begin
            e_w[0] <= e_w[1];
            e_a[0] <= e_a[1];
            e_d0[0] <= e_d0[1];
            e_d1[0] <= e_d1[1];
         end
         if (push) begin
            e_w[1'(cnt_r - pop)] <= cmd_write_i;
            e_a[1'(cnt_r - pop)] <= cmd_addr_i;
            e_d0[1'(cnt_r - pop)] <= cmd_wdata0_i & USED_MASK;
            e_d1[1'(cnt_r - pop)] <= cmd_wdata1_i & USED_MASK;
         end
      end
   end

   // pins change mid-phase so the memory samples them settled
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rd_last_r <= 1'b0;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         byp_n_r <= 1'b1;
         addr_r <= '0;
         wd_r <= '0;
         pw_act_r <= 1'b0;
         pw_addr_r <= '0;
         pw_d1_r <= '0;
      end else begin
         byp_n_r <= ~dll_bypass_req_i;
         if (slot) begin
            rd_last_r <= issue_r;
            rd_n_r <= ~issue_r;
            wr_n_r <= ~issue_w;
            pw_act_r <= issue_w;
            if (issue_r) begin
               addr_r <= e_a[ri];
            end
            if (issue_w) begin
               wd_r <= e_d0[wi];
               pw_addr_r <= e_a[wi];
               pw_d1_r <= e_d1[wi];
            end
         end else if (div_r == SLOT_FALL_PREP && pw_act_r) begin
            addr_r <= pw_addr_r;
            wd_r <= pw_d1_r;
         end
      end
   end

   // capture each word on the echo edge that carries it
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ep_r <= 1'b0;
         rv_r <= 1'b0;
         rd0_r <= '0;
         rd1_r <= '0;
      end else begin
         ep_r <= lk.echo_timing_pos;
         rv_r <= 1'b0;
         if (ep_r != lk.echo_timing_pos && lk.output_valid_flag && lk.fetch_oe) begin
            if (!lk.echo_timing_pos) begin
               rd0_r <= lk.fetch_bus & USED_MASK;
            end else begin
               rd1_r <= lk.fetch_bus & USED_MASK;
               rv_r <= 1'b1;
            end
         end
      end
   end

   assign lk.input_timing_pos = k_r;
   assign lk.input_timing_neg = kn_r;
   assign lk.read_select_n = rd_n_r;
   assign lk.write_select_n = wr_n_r;
   assign lk.dll_bypass_n = byp_n_r;
   assign lk.port_address = addr_r;
   assign lk.write_bus = wd_r;
   assign cmd_ready_o = ready_r;
   assign rd_valid_o = rv_r;
   assign rd_data0_o = rd0_r;
   assign rd_data1_o = rd1_r;
endmodule

/* File: logic/ddrb_link_if.sv */
// pin bundle between the memory end and the controller end
`timescale 1ns/1ps
interface ddrb_link_if;
   import ddrb_pkg::*;
   logic input_timing_pos;
   logic input_timing_neg;
   logic read_select_n;
   logic write_select_n;
   logic dll_bypass_n;
   logic [ADDR_W-1:0] port_address;
   logic [DATA_W-1:0] write_bus;
   logic [DATA_W-1:0] fetch_bus;
   logic fetch_oe;
   logic echo_timing_pos;
   logic echo_timing_neg;
   logic output_valid_flag;
   modport mem (
      input input_timing_pos, input_timing_neg, read_select_n, write_select_n,
      input dll_bypass_n, port_address, write_bus,
      output fetch_bus, fetch_oe, echo_timing_pos, echo_timing_neg, output_valid_flag
   );
   modport ctl (
      output input_timing_pos, input_timing_neg, read_select_n, write_select_n,
      output dll_bypass_n, port_address, write_bus,
      input fetch_bus, fetch_oe, echo_timing_pos, echo_timing_neg, output_valid_flag
   );
endinterface

/* File: logic/ddrb_mem_end.sv */
// memory end: samples the input clock pair and serves read and write bursts
`timescale 1ns/1ps
// Functional notes
// - control and read address on pos rise, write address on neg rise, data both rises
// - controller drives neg as complement of pos
// - echo clocks toggle always, even bus off
// - echo edges aligned with read data changes
// - bypass low: skip loop, forget lock
// - bypass high: loop locks after lock time
// - bypassed loop gives one-cycle read latency; model gives 1.5 cycles, one less than the 2.5 with the loop
// - valid flag marks data, aligned to echo
// - address taken only when a select low
// - narrow variant uses write bits 0-17
// - narrow variant drives fetch bits 0-17
// - fetch bus driven only for reads
// - write select low starts write cycle
// - read select low starts read cycle
// - reads at most every other cycle
// - word0 on neg rise, word1 next pos
// - write word0 with select, address later
// - read of last write returns buffer
module ddrb_mem_end
   import ddrb_pkg::*;
#(
   parameter int LOCK_KCYC = DLL_LOCK_KCYC
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   ddrb_link_if.mem lk,
   output logic dll_locked_o
);
   localparam int IN_W = 5 + ADDR_W + DATA_W;
   // idle pin levels: selects and bypass high, so reset leaves no false bypass
   localparam logic [IN_W-1:0] IN_IDLE = {5'b00111, {(ADDR_W + DATA_W){1'b0}}};

   logic [IN_W-1:0] s1_r;
   logic [IN_W-1:0] s2_r;
   logic [IN_W-1:0] s3_r;
   logic k_lvl_r;
   logic kn_lvl_r;
   logic byp_n_lvl_r;
   logic k_rise;
   logic kn_rise;
   logic half_edge;
   logic rd_n_s;
   logic wr_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic [PIPE_LEN-1:0] pv_r;
   logic [ADDR_W-1:0] pa_r [PIPE_LEN];
   logic wr_pend_r;
   logic [DATA_W-1:0] w0_r;
   logic wb_vld_r;
   logic [ADDR_W-1:0] wb_addr_r;
   logic [DATA_W-1:0] wb_d0_r;
   logic [DATA_W-1:0] wb_d1_r;
   logic [DATA_W-1:0] mem [2**(MEM_BA_W+1)];
   logic [15:0] lock_cnt_r;
   logic locked_r;
   logic cq_r;
   logic cqn_r;
   logic qv_r;
   logic oe_r;
   logic [DATA_W-1:0] q_r;

   // three-stage capture of every pin; stage three feeds the logic, stage two also feeds the clock and bypass level checks
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         s1_r <= IN_IDLE;
         s2_r <= IN_IDLE;
         s3_r <= IN_IDLE;
      end else begin
         s1_r <= {lk.input_timing_pos, lk.input_timing_neg, lk.read_select_n,
                  lk.write_select_n, lk.dll_bypass_n, lk.port_address, lk.write_bus};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign rd_n_s = s3_r[IN_W-3];
   assign wr_n_s = s3_r[IN_W-4];
   assign addr_s = s3_r[DATA_W +: ADDR_W];
   assign data_s = s3_r[DATA_W-1:0] & USED_MASK;

   // a clock level counts once stages two and three agree
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         k_lvl_r <= 1'b0;
         kn_lvl_r <= 1'b0;
         byp_n_lvl_r <= 1'b1;
      end else begin
         if (s2_r[IN_W-1] == s3_r[IN_W-1]) begin
            k_lvl_r <= s3_r[IN_W-1];
         end
         if (s2_r[IN_W-2] == s3_r[IN_W-2]) begin
            kn_lvl_r <= s3_r[IN_W-2];
         end
         if (s2_r[IN_W-5] == s3_r[IN_W-5]) begin
            byp_n_lvl_r <= s3_r[IN_W-5];
         end
      end
   end

   // neg rise stands in for pos fall, valid since neg is the complement
   assign k_rise = (s2_r[IN_W-1] & s3_r[IN_W-1]) & ~k_lvl_r;
   assign kn_rise = (s2_r[IN_W-2] & s3_r[IN_W-2]) & ~kn_lvl_r;
   assign half_edge = k_rise | kn_rise;

   // loop lock model: counted in input clock periods
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         lock_cnt_r <= '0;
         locked_r <= 1'b0;
      end else if (!byp_n_lvl_r) begin
         lock_cnt_r <= '0;
         locked_r <= 1'b0;
      end else if (k_rise && !locked_r) begin
         if (lock_cnt_r == 16'(LOCK_KCYC - 1)) begin
            locked_r <= 1'b1;
         end else begin
            lock_cnt_r <= lock_cnt_r + 16'h0001;
         end
      end
   end

   // read pipe in half-edges; bypass enters two half-edges further on
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pv_r <= '0;
         for (int i = 0; i < PIPE_LEN; i++) begin
            pa_r[i] <= '0;
         end
      end else if (half_edge) begin
         pv_r <= {pv_r[PIPE_LEN-2:0], 1'b0};
         for (int i = 1; i < PIPE_LEN; i++) begin
            pa_r[i] <= pa_r[i-1];
         end
         // reads two cycles apart never collide in the pipe
         if (k_rise && !rd_n_s) begin
            if (!byp_n_lvl_r) begin
               pv_r[PIPE_IN_BYP] <= 1'b1;
               pa_r[PIPE_IN_BYP] <= addr_s;
            end else begin
               pv_r[PIPE_IN_DLL] <= 1'b1;
               pa_r[PIPE_IN_DLL] <= addr_s;
            end
         end
      end
   end

   // write: word0 with select on pos rise, address and word1 on neg rise
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         wr_pend_r <= 1'b0;
         w0_r <= '0;
         wb_vld_r <= 1'b0;
         wb_addr_r <= '0;
         wb_d0_r <= '0;
         wb_d1_r <= '0;
      end else if (k_rise) begin
         wr_pend_r <= ~wr_n_s;
         if (!wr_n_s) begin
            w0_r <= data_s;
         end
      end else if (kn_rise && wr_pend_r) begin
         wr_pend_r <= 1'b0;
         wb_vld_r <= 1'b1;
         wb_addr_r <= addr_s;
         wb_d0_r <= w0_r;
         wb_d1_r <= data_s;
      end
   end

   // buffered burst reaches the array only when the next one arrives
   always_ff @(posedge clock_i) begin
      if (kn_rise && wr_pend_r && wb_vld_r) begin
         mem[{wb_addr_r[MEM_BA_W-1:0], 1'b0}] <= wb_d0_r;
         mem[{wb_addr_r[MEM_BA_W-1:0], 1'b1}] <= wb_d1_r;
      end
   end

   function automatic logic [DATA_W-1:0] fetch_word(input logic [ADDR_W-1:0] a,
                                                     input logic beat);
      logic [DATA_W-1:0] w;
      w = mem[{a[MEM_BA_W-1:0], beat}];
      if (wb_vld_r && (wb_addr_r == a)) begin
         w = beat ? wb_d1_r : wb_d0_r;
      end
      return w & USED_MASK;
   endfunction

   // echo clocks follow every input edge, read or not
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cq_r <= 1'b0;
         cqn_r <= 1'b1;
      end else if (k_rise) begin
         cq_r <= 1'b1;
         cqn_r <= 1'b0;
      end else if (kn_rise) begin
         cq_r <= 1'b0;
         cqn_r <= 1'b1;
      end
   end

   // data, valid and enable change in the same cycle as the echo edge
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         q_r <= '0;
         qv_r <= 1'b0;
         oe_r <= 1'b0;
      end else if (half_edge) begin
         if (pv_r[PIPE_W0]) begin
            q_r <= fetch_word(pa_r[PIPE_W0], 1'b0);
            qv_r <= 1'b1;
            oe_r <= 1'b1;
         end else if (pv_r[PIPE_W1]) begin
            q_r <= fetch_word(pa_r[PIPE_W1], 1'b1);
            qv_r <= 1'b1;
            oe_r <= 1'b1;
         end else begin
            qv_r <= 1'b0;
            oe_r <= 1'b0;
         end
      end
   end

   assign lk.fetch_bus = q_r;
   assign lk.fetch_oe = oe_r;
   assign lk.echo_timing_pos = cq_r;
   assign lk.echo_timing_neg = cqn_r;
   assign lk.output_valid_flag = qv_r;
   assign dll_locked_o = locked_r;
endmodule

/* File: logic/ddrb_pkg.sv */
// shared constants for the burst-of-two sram link
package ddrb_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 36;
   // data bits in use: 36 for the wide variant, 18 for the narrow one
   localparam int USED_W = 36;
   // burst addresses held in the model array (low address bits only)
   localparam int MEM_BA_W = 5;
   localparam int CLK_PERIOD_NS = 25;
   localparam int K_PERIOD_NS = 400;
   localparam int KPER = K_PERIOD_NS / CLK_PERIOD_NS;
   localparam int KHALF = KPER / 2;
   localparam int BYPASS_FMAX_MHZ = 167;
   localparam int K_FREQ_KHZ = 1000000 / K_PERIOD_NS;
   localparam logic [3:0] DIV_LAST = 4'(KPER - 1);
   localparam logic [3:0] DIV_FALL = 4'(KHALF - 1);
   localparam logic [3:0] SLOT_RISE_PREP = 4'hC;
   localparam logic [3:0] SLOT_FALL_PREP = 4'h4;
   // pipe index where a read enters, counted in clock half-edges
   localparam logic [2:0] PIPE_IN_DLL = 3'h0;
   localparam logic [2:0] PIPE_IN_BYP = 3'h2;
   localparam int PIPE_W0 = 4;
   localparam int PIPE_W1 = 5;
   localparam int PIPE_LEN = 7;
   localparam int DLL_LOCK_KCYC = 1024;
   localparam logic [DATA_W-1:0] USED_MASK = DATA_W'((37'h1 << USED_W) - 37'h1);
endpackage

/* File: verification/ddrb_link_sva.sv */
// assertions on the burst-of-two link pins
`timescale 1ns/1ps
module ddrb_link_sva
   import ddrb_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic input_timing_pos,
   input wire logic input_timing_neg,
   input wire logic read_select_n,
   input wire logic [ADDR_W-1:0] port_address,
   input wire logic [DATA_W-1:0] fetch_bus,
   input wire logic fetch_oe,
   input wire logic echo_timing_pos,
   input wire logic echo_timing_neg,
   input wire logic output_valid_flag
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic [5:0] vrun_r;
   logic [5:0] echo_idle_r;
   logic [1:0] pend_r;
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || !output_valid_flag) vrun_r <= 6'h00;
      else vrun_r <= vrun_r + 6'h01;
   end
   // saturates so a stuck echo keeps the count high
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || $changed(echo_timing_pos)) echo_idle_r <= 6'h00;
      else if (echo_idle_r != 6'h3F) echo_idle_r <= echo_idle_r + 6'h01;
   end
   // reads taken at pin rises but not yet answered
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) pend_r <= 2'h0;
      else pend_r <= pend_r + 2'($rose(input_timing_pos) && !read_select_n)
         - 2'($rose(output_valid_flag));
   end
   sequence s_word0; output_valid_flag && !echo_timing_pos; endsequence
   sequence s_word1; output_valid_flag && echo_timing_pos; endsequence
   sequence s_quiet8; read_select_n [*8]; endsequence
   property p_neg_comp; input_timing_neg == !input_timing_pos; endproperty
   property p_echo_comp; echo_timing_neg == !echo_timing_pos; endproperty
   property p_echo_runs; echo_idle_r < 6'h14; endproperty
   property p_oe_valid; fetch_oe == output_valid_flag; endproperty
   property p_valid_len; $fell(output_valid_flag) |-> vrun_r == 6'h10; endproperty
   property p_read_pend; $rose(output_valid_flag) |-> pend_r inside {2'h1, 2'h2}; endproperty
   property p_echo_aligned;
      $changed(output_valid_flag) || (fetch_oe && $changed(fetch_bus))
         |-> $changed(echo_timing_pos);
   endproperty
   property p_burst; $rose(output_valid_flag) |-> s_word0 ##8 s_word1; endproperty
   property p_read_gap; $rose(read_select_n) |-> s_quiet8 ##1 s_quiet8; endproperty
   property p_addr_hold;
      $rose(input_timing_pos) && !read_select_n |-> $stable(port_address);
   endproperty
   a_neg_comp: assert property (p_neg_comp) else $error("k pair not inverse");
   a_echo_comp: assert property (p_echo_comp) else $error("echo pair not inverse");
   a_echo_runs: assert property (p_echo_runs) else $error("echo clock stopped");
   a_oe_valid: assert property (p_oe_valid) else $error("enable and valid differ");
   a_valid_len: assert property (p_valid_len) else $error("valid not two halves");
   a_read_pend: assert property (p_read_pend) else $error("data without read");
   a_echo_aligned: assert property (p_echo_aligned) else $error("data off echo");
   a_burst: assert property (p_burst) else $error("burst words misplaced");
   a_read_gap: assert property (p_read_gap) else $error("reads too close");
   a_addr_hold: assert property (p_addr_hold) else $error("address moved at rise");
endmodule

/* File: verification/tb_top.sv */
// self-checking bench joining the memory end and the controller end
`timescale 1ns/1ps
module tb_top
   import ddrb_pkg::*;
;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   logic cmd_write_i = 1'b0;
   logic dll_bypass_req_i = 1'b0;
   logic [ADDR_W-1:0] cmd_addr_i = '0;
   logic [DATA_W-1:0] cmd_wdata0_i = '0;
   logic [DATA_W-1:0] cmd_wdata1_i = '0;
   logic cmd_ready_o;
   logic rd_valid_o;
   logic [DATA_W-1:0] rd_data0_o;
   logic [DATA_W-1:0] rd_data1_o;
   logic dll_locked_o;
   int fails = 0;
   int compares = 0;
   int refused = 0;
   int cyc = 0;
   ddrb_link_if lk ();
   // short lock time keeps the run brief
   ddrb_mem_end #(.LOCK_KCYC(4)) ddrb_mem_end_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .lk(lk), .dll_locked_o(dll_locked_o));
   ddrb_ctl_end ddrb_ctl_end_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .lk(lk),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_write_i(cmd_write_i),
      .cmd_addr_i(cmd_addr_i), .cmd_wdata0_i(cmd_wdata0_i), .cmd_wdata1_i(cmd_wdata1_i),
      .dll_bypass_req_i(dll_bypass_req_i), .rd_valid_o(rd_valid_o),
      .rd_data0_o(rd_data0_o), .rd_data1_o(rd_data1_o));
   ddrb_link_sva ddrb_link_sva_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .input_timing_pos(lk.input_timing_pos), .input_timing_neg(lk.input_timing_neg),
      .read_select_n(lk.read_select_n), .port_address(lk.port_address),
      .fetch_bus(lk.fetch_bus), .fetch_oe(lk.fetch_oe),
      .echo_timing_pos(lk.echo_timing_pos), .echo_timing_neg(lk.echo_timing_neg),
      .output_valid_flag(lk.output_valid_flag));
   always #12.5 clock_i = ~clock_i;
   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         $display("[ERR] %0t run timed out", $time);
         close_out();
      end
   end
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // leaves valid up so a following command queues without a gap
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d0, input logic [DATA_W-1:0] d1);
      int n;
      if (cmd_valid_i !== 1'b1) cmd_valid_i <= 1'b1;
      cmd_write_i <= wr;
      cmd_addr_i <= a;
      cmd_wdata0_i <= d0;
      cmd_wdata1_i <= d1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
         if (cmd_ready_o !== 1'b1) refused++;
      end while (cmd_ready_o !== 1'b1 && n < 400);
      check(DATA_W'(cmd_ready_o), 36'h1);
   endtask
   // latency counted from the select pin, since queue wait varies
   task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e0,
         input logic [DATA_W-1:0] e1, output int lat);
      issue(1'b0, a, '0, '0);
      cmd_valid_i <= 1'b0;
      lat = 0;
      while (lk.read_select_n !== 1'b0 && lat < 300) begin
         @(posedge clock_i);
         lat++;
      end
      check(DATA_W'(lk.read_select_n), 36'h0);
      lat = 0;
      while (rd_valid_o !== 1'b1 && lat < 300) begin
         @(posedge clock_i);
         lat++;
      end
      check(DATA_W'(rd_valid_o), 36'h1);
      check(rd_data0_o, e0);
      check(rd_data1_o, e1);
   endtask
   task automatic t_wr_rd();
      int l;
      issue(1'b1, 20'h00005, 36'hA5A5A5A5A, 36'h5A5A5A5A5);
      cmd_valid_i <= 1'b0;
      // one edge with valid low, so the next call sees the drop
      @(posedge clock_i);
      read_chk(20'h00005, 36'hA5A5A5A5A, 36'h5A5A5A5A5, l);
      issue(1'b1, 20'h00006, 36'h800000001, 36'h0FEDCBA98);
      cmd_valid_i <= 1'b0;
      @(posedge clock_i);
      read_chk(20'h00005, 36'hA5A5A5A5A, 36'h5A5A5A5A5, l);
      read_chk(20'h00006, 36'h800000001, 36'h0FEDCBA98, l);
   endtask
   task automatic t_concur();
      int l;
      issue(1'b1, 20'h00007, 36'h123456789, 36'hFFFFFFFFF);
      read_chk(20'h00006, 36'h800000001, 36'h0FEDCBA98, l);
      read_chk(20'h00007, 36'h123456789, 36'hFFFFFFFFF, l);
   endtask
   // four writes with valid held: the two-entry queue must push back
   task automatic t_flood();
      int l;
      refused = 0;
      for (int i = 0; i < 4; i++) begin
         issue(1'b1, ADDR_W'(8 + i), 36'(i + 1) * 36'h111111111, ~(36'(i + 1) * 36'h111111111));
      end
      cmd_valid_i <= 1'b0;
      check(DATA_W'(refused > 0), 36'h1);
      @(posedge clock_i);
      for (int i = 0; i < 4; i++) begin
         read_chk(ADDR_W'(8 + i), 36'(i + 1) * 36'h111111111, ~(36'(i + 1) * 36'h111111111), l);
      end
   endtask
   task automatic t_lock();
      int lb;
      int ld;
      dll_bypass_req_i <= 1'b1;
      repeat (40) @(posedge clock_i);
      check(DATA_W'(dll_locked_o), 36'h0);
      read_chk(20'h00007, 36'h123456789, 36'hFFFFFFFFF, lb);
      dll_bypass_req_i <= 1'b0;
      repeat (20) @(posedge clock_i);
      check(DATA_W'(dll_locked_o), 36'h0);
      repeat (150) @(posedge clock_i);
      check(DATA_W'(dll_locked_o), 36'h1);
      read_chk(20'h00007, 36'h123456789, 36'hFFFFFFFFF, ld);
      check(DATA_W'(ld - lb), 36'h10);
   endtask
   task automatic t_idle_echo();
      int k;
      logic last;
      // the last read still shows valid for one half period
      repeat (16) @(posedge clock_i);
      k = 0;
      last = lk.echo_timing_pos;
      repeat (64) begin
         @(posedge clock_i);
         if (lk.echo_timing_pos !== last) k++;
         last = lk.echo_timing_pos;
         check(DATA_W'(lk.fetch_oe), 36'h0);
      end
      check(DATA_W'(k), 36'h8);
   endtask
   initial begin
      repeat (12) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      t_wr_rd();
      t_concur();
      t_flood();
      t_lock();
      t_idle_echo();
      close_out();
   end
endmodule
